//--- verilog/cbsc_pkg.sv
// constants for the can buffer status and control block
// Contract
// - mask one bit compares, zero ignores
// - received message sets buffer full flag
// - receive into full buffer sets overflow
// - direction bit one transmit, zero receive
// - control word: low even, high odd
// - aborted flag shows aborted versus completed
// - lost arbitration flag set on loss
// - bus error flag set on transmit error
// - setting transmit request clears three flags
// - request set by software, cleared on success
// - writing zero to pending request aborts
// - remote frame sets request when enabled
// - two bit priority, three is highest
// - first word holds standard id, upper zero
// - first word bit one is srr
// - first word bit zero is ide
// - second word holds extended id 17:6
// - status word records filter hit code
package cbsc_pkg;
    localparam int NUM_BUF   = 32;
    localparam int NUM_TX    = 8;
    localparam int ADDR_W    = 8;
    // register map, one 16-bit register per address
    localparam logic [7:0] ADR_MASK_EID    = 8'h00;
    localparam logic [7:0] ADR_RX_FULL_FLAG_LO    = 8'h04;
    localparam logic [7:0] ADR_RX_FULL_FLAG_HI    = 8'h05;
    localparam logic [7:0] ADR_RX_OVERFLOW_FLAG_LO    = 8'h06;
    localparam logic [7:0] ADR_RX_OVERFLOW_FLAG_HI    = 8'h07;
    localparam logic [7:0] ADR_PAIR_CTRL   = 8'h08;
    localparam logic [2:0] REG_SID_WORD    = 3'h2;
    localparam logic [2:0] REG_EID_WORD    = 3'h3;
    localparam logic [2:0] REG_STAT_WORD   = 3'h4;
    // control byte layout, same in both halves of a pair register
    localparam int CTL_DIR_SELECT     = 7;
    localparam int CTL_ABORTED        = 6;
    localparam int CTL_LOST_ARB       = 5;
    localparam int CTL_BUS_ERROR      = 4;
    localparam int CTL_TX_REQUEST     = 3;
    localparam int CTL_AUTO_REPLY     = 2;
    localparam int CTL_PRIORITY_LSB   = 0;
    localparam logic [7:0] CTL_WR_MASK = 8'h8F;
    // identifier word layout
    localparam int SID_FIELD_LSB = 2;
    localparam int SID_SRR_BIT   = 1;
    localparam int SID_IDE_BIT   = 0;
    localparam int STAT_HIT_LSB  = 8;
    // reset values
    localparam logic [31:0] RST_FLAGS = 32'h0000_0000;
    localparam logic [7:0]  RST_CTRL  = 8'h00;
    localparam logic [15:0] RST_WORD  = 16'h0000;
endpackage

//--- verilog/cbsc_core.sv
// can message buffer bookkeeping: masks, rx flags, tx control, id words
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/100ps
module cbsc_core
    import cbsc_pkg::*;
#(
    parameter int NUM_MASK = 3
)(
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    // register port
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [15:0]       wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [15:0]       rdata_out,
    // extended id mask comparison
    input  wire logic [15:0]       filt_eid_in,
    input  wire logic [15:0]       msg_eid_in,
    input  wire logic [1:0]        mask_sel_in,
    output logic                   ext_match_out,
    // received message store
    input  wire logic              rx_write_in,
    input  wire logic [4:0]        rx_buf_in,
    input  wire logic [10:0]       rx_sid_in,
    input  wire logic              rx_srr_in,
    input  wire logic              rx_ide_in,
    input  wire logic [11:0]       rx_eid_in,
    input  wire logic [4:0]        rx_filter_hit_in,
    // remote frame reception
    input  wire logic              rtr_rx_in,
    input  wire logic [2:0]        rtr_buf_in,
    // transmit engine
    input  wire logic              tx_ok_in,
    input  wire logic              tx_lost_arb_in,
    input  wire logic              tx_bus_err_in,
    output logic                   tx_valid_out,
    output logic      [2:0]        tx_buf_out,
    output logic      [7:0]        tx_abort_out
);

    typedef struct packed {
        logic [NUM_MASK-1:0][15:0] mask;
        logic [NUM_BUF-1:0]        full;
        logic [NUM_BUF-1:0]        ovf;
        logic [NUM_TX-1:0][7:0]    ctrl;
        logic [NUM_BUF-1:0][12:0]  sidw;
        logic [NUM_BUF-1:0][11:0]  eidw;
        logic [NUM_BUF-1:0][4:0]   hit;
        logic [15:0]               rdata;
        logic                      ext_match;
        logic                      tx_valid;
        logic [2:0]                tx_buf;
        logic [7:0]                tx_abort;
    } cbsc_state_s;

    cbsc_state_s st_r;
    cbsc_state_s st_nxt;

    logic [4:0] word_idx;
    logic       in_low;
    logic [2:0] region;

    assign word_idx = addr_in[4:0];
    assign in_low   = (addr_in[7:4] == 4'h0);
    assign region   = addr_in[7:5];

    // read mux; unmapped addresses read zero
    function automatic logic [15:0] read_word(input cbsc_state_s s,
                                              input logic [7:0] a);
        logic [15:0] v;
        logic [1:0]  pr;
        v  = 16'h0000;
        pr = a[1:0];
        if (a[7:4] == 4'h0) begin
            if (a < ADR_RX_FULL_FLAG_LO) begin
                if (int'(a[1:0]) < NUM_MASK) begin
                    v = s.mask[a[1:0]];
                end
            end else if (a == ADR_RX_FULL_FLAG_LO) begin
                v = s.full[15:0];
            end else if (a == ADR_RX_FULL_FLAG_HI) begin
                v = s.full[31:16];
            end else if (a == ADR_RX_OVERFLOW_FLAG_LO) begin
                v = s.ovf[15:0];
            end else if (a == ADR_RX_OVERFLOW_FLAG_HI) begin
                v = s.ovf[31:16];
            end else if (a[3:2] == ADR_PAIR_CTRL[3:2]) begin
                v = {s.ctrl[{pr, 1'b1}], s.ctrl[{pr, 1'b0}]};
            end
        end else if (a[7:5] == REG_SID_WORD) begin
            v = {3'b000, s.sidw[a[4:0]]};
        end else if (a[7:5] == REG_EID_WORD) begin
            v = {4'h0, s.eidw[a[4:0]]};
        end else if (a[7:5] == REG_STAT_WORD) begin
            v = {3'b000, s.hit[a[4:0]], 8'h00};
        end
        return v;
    endfunction

    always_comb begin
        logic [7:0] old_b;
        logic [7:0] new_b;
        logic [7:0] wb;
        logic [2:0] k;
        logic [1:0] best_pri;
        logic       found;
        logic [2:0] best_idx;
        logic [2:0] cur;
        old_b    = 8'h00;
        new_b    = 8'h00;
        wb       = 8'h00;
        k        = 3'd0;
        best_pri = 2'd0;
        found    = 1'b0;
        best_idx = 3'd0;
        cur      = st_r.tx_buf;
        st_nxt          = st_r;
        st_nxt.tx_abort = 8'h00;
        st_nxt.rdata    = 16'h0000;

        // read data stands only in the cycle after the strobe
        if (rd_in) begin
            st_nxt.rdata = read_word(st_r, addr_in);
        end

        // software writes first; hardware events below win over them
        if (wr_in && in_low) begin
            if (addr_in < ADR_RX_FULL_FLAG_LO) begin
                if (int'(addr_in[1:0]) < NUM_MASK) begin
                    st_nxt.mask[addr_in[1:0]] = wdata_in;
                end
            end else if (addr_in == ADR_RX_FULL_FLAG_LO) begin
                st_nxt.full[15:0] = st_r.full[15:0] & wdata_in;
            end else if (addr_in == ADR_RX_FULL_FLAG_HI) begin
                st_nxt.full[31:16] = st_r.full[31:16] & wdata_in;
            end else if (addr_in == ADR_RX_OVERFLOW_FLAG_LO) begin
                st_nxt.ovf[15:0] = st_r.ovf[15:0] & wdata_in;
            end else if (addr_in == ADR_RX_OVERFLOW_FLAG_HI) begin
                st_nxt.ovf[31:16] = st_r.ovf[31:16] & wdata_in;
            end else if (addr_in[3:2] == ADR_PAIR_CTRL[3:2]) begin
                for (int b = 0; b < 2; b++) begin
                    k     = {addr_in[1:0], b[0]};
                    old_b = st_r.ctrl[k];
                    wb    = wdata_in[8*b +: 8];
                    // status bits are read only
                    new_b = (old_b & ~CTL_WR_MASK) | (wb & CTL_WR_MASK);
                    if (!old_b[CTL_TX_REQUEST] && wb[CTL_TX_REQUEST]) begin
                        new_b[CTL_ABORTED]   = 1'b0;
                        new_b[CTL_LOST_ARB]  = 1'b0;
                        new_b[CTL_BUS_ERROR] = 1'b0;
                    end
                    if (old_b[CTL_TX_REQUEST] && !wb[CTL_TX_REQUEST]) begin
                        new_b[CTL_ABORTED] = 1'b1;
                        st_nxt.tx_abort[k] = 1'b1;
                    end
                    st_nxt.ctrl[k] = new_b;
                end
            end
        end else if (wr_in && region == REG_SID_WORD) begin
            st_nxt.sidw[word_idx] = wdata_in[12:0];
        end else if (wr_in && region == REG_EID_WORD) begin
            st_nxt.eidw[word_idx] = wdata_in[11:0];
        end else if (wr_in && region == REG_STAT_WORD) begin
            st_nxt.hit[word_idx] = wdata_in[STAT_HIT_LSB +: 5];
        end

        // received message lands in its buffer
        if (rx_write_in) begin
            if (st_r.full[rx_buf_in]) begin
                st_nxt.ovf[rx_buf_in] = 1'b1;
            end
            st_nxt.full[rx_buf_in] = 1'b1;
            st_nxt.sidw[rx_buf_in] = {rx_sid_in, rx_srr_in, rx_ide_in};
            st_nxt.eidw[rx_buf_in] = rx_eid_in;
            st_nxt.hit[rx_buf_in] = rx_filter_hit_in;
        end

        if (rtr_rx_in && st_r.ctrl[rtr_buf_in][CTL_AUTO_REPLY]) begin
            if (!st_nxt.ctrl[rtr_buf_in][CTL_TX_REQUEST]) begin
                st_nxt.ctrl[rtr_buf_in][CTL_ABORTED]   = 1'b0;
                st_nxt.ctrl[rtr_buf_in][CTL_LOST_ARB]  = 1'b0;
                st_nxt.ctrl[rtr_buf_in][CTL_BUS_ERROR] = 1'b0;
            end
            st_nxt.ctrl[rtr_buf_in][CTL_TX_REQUEST] = 1'b1;
        end

        // results apply to the buffer offered in this cycle
        if (st_r.tx_valid) begin
            if (tx_ok_in) begin
                st_nxt.ctrl[cur][CTL_TX_REQUEST] = 1'b0;
                st_nxt.ctrl[cur][CTL_ABORTED]    = 1'b0;
            end
            if (tx_lost_arb_in) begin
                st_nxt.ctrl[cur][CTL_LOST_ARB] = 1'b1;
            end
            if (tx_bus_err_in) begin
                st_nxt.ctrl[cur][CTL_BUS_ERROR] = 1'b1;
            end
        end

        for (int i = 0; i < NUM_TX; i++) begin
            if (st_nxt.ctrl[i][CTL_TX_REQUEST] &&
                st_nxt.ctrl[i][CTL_DIR_SELECT]) begin
                if (!found ||
                    st_nxt.ctrl[i][CTL_PRIORITY_LSB +: 2] > best_pri) begin
                    found    = 1'b1;
                    best_pri = st_nxt.ctrl[i][CTL_PRIORITY_LSB +: 2];
                    best_idx = i[2:0];
                end
            end
        end
        st_nxt.tx_valid = found;
        st_nxt.tx_buf   = best_idx;

        if (int'(mask_sel_in) < NUM_MASK) begin
            st_nxt.ext_match = (((filt_eid_in ^ msg_eid_in) &
                                 st_r.mask[mask_sel_in]) == 16'h0000);
        end else begin
            st_nxt.ext_match = 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r.mask      <= '0;
            st_r.full      <= RST_FLAGS;
            st_r.ovf       <= RST_FLAGS;
            st_r.ctrl      <= {NUM_TX{RST_CTRL}};
            st_r.sidw      <= '0;
            st_r.eidw      <= '0;
            st_r.hit       <= '0;
            st_r.rdata     <= RST_WORD;
            st_r.ext_match <= 1'b0;
            st_r.tx_valid  <= 1'b0;
            st_r.tx_buf    <= 3'd0;
            st_r.tx_abort  <= 8'h00;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_out     = st_r.rdata;
    assign ext_match_out = st_r.ext_match;
    assign tx_valid_out  = st_r.tx_valid;
    assign tx_buf_out    = st_r.tx_buf;
    assign tx_abort_out  = st_r.tx_abort;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    // pair control view, watched by the read check
    logic [15:0] pair_view;
    assign pair_view = {st_r.ctrl[{addr_in[1:0], 1'b1}],
                        st_r.ctrl[{addr_in[1:0], 1'b0}]};

    sequence ctrl_read_s;
        rd_in && in_low && (addr_in[3:2] == ADR_PAIR_CTRL[3:2]);
    endsequence

    sequence id_read_s;
        rd_in && (region == REG_SID_WORD || region == REG_EID_WORD);
    endsequence

    ext_match_a: assert property (
        (!rst_in && !wr_in && int'(mask_sel_in) < NUM_MASK) |=>
            ext_match_out ==
            ((($past(filt_eid_in) ^ $past(msg_eid_in)) &
              st_r.mask[$past(mask_sel_in)]) == 16'h0000)
    ) else $error("extended mask comparison wrong");

    rx_full_a: assert property (
        rx_write_in |=> st_r.full[$past(rx_buf_in)]
    ) else $error("full flag not set by receive");

    full_hold_a: assert property (
        !wr_in |=> (st_r.full & $past(st_r.full)) == $past(st_r.full)
    ) else $error("full flag dropped without software");

    rx_ovf_a: assert property (
        (rx_write_in && st_r.full[rx_buf_in]) |=> st_r.ovf[$past(rx_buf_in)]
    ) else $error("overflow flag not set");

    ovf_hold_a: assert property (
        !wr_in |=> (st_r.ovf & $past(st_r.ovf)) == $past(st_r.ovf)
    ) else $error("overflow flag dropped without software");

    ctrl_read_a: assert property (
        ctrl_read_s |=> rdata_out == $past(pair_view)
    ) else $error("pair control read wrong");

    id_zero_a: assert property (
        id_read_s |=> rdata_out[15:13] == 3'b000
    ) else $error("unimplemented id bits not zero");

    tx_ok_a: assert property (
        (tx_ok_in && tx_valid_out && !wr_in && !rtr_rx_in) |=>
            !st_r.ctrl[$past(tx_buf_out)][CTL_TX_REQUEST]
    ) else $error("request not cleared after success");

    tx_done_a: assert property (
        (tx_ok_in && tx_valid_out) |=>
            !st_r.ctrl[$past(tx_buf_out)][CTL_ABORTED]
    ) else $error("aborted flag set after success");

    lost_arb_a: assert property (
        (tx_lost_arb_in && tx_valid_out && !rtr_rx_in) |=>
            st_r.ctrl[$past(tx_buf_out)][CTL_LOST_ARB]
    ) else $error("lost arbitration not flagged");

    bus_err_a: assert property (
        (tx_bus_err_in && tx_valid_out && !rtr_rx_in) |=>
            st_r.ctrl[$past(tx_buf_out)][CTL_BUS_ERROR]
    ) else $error("bus error not flagged");

    tx_dir_a: assert property (
        tx_valid_out |-> st_r.ctrl[tx_buf_out][CTL_DIR_SELECT] &&
            st_r.ctrl[tx_buf_out][CTL_TX_REQUEST]
    ) else $error("receive buffer offered");

    rx_bits_a: assert property (
        rx_write_in |=>
            st_r.sidw[$past(rx_buf_in)][SID_SRR_BIT] == $past(rx_srr_in) &&
            st_r.sidw[$past(rx_buf_in)][SID_IDE_BIT] == $past(rx_ide_in)
    ) else $error("srr or ide not stored");

    rx_eid_a: assert property (
        rx_write_in |=> st_r.eidw[$past(rx_buf_in)] == $past(rx_eid_in)
    ) else $error("extended id not stored");

    rx_hit_a: assert property (
        rx_write_in |=>
            st_r.hit[$past(rx_buf_in)] == $past(rx_filter_hit_in)
    ) else $error("filter hit code not stored");

    for (genvar i = 0; i < NUM_TX; i++) begin : g_chk
        flags_clear_a: assert property (
            $rose(st_r.ctrl[i][CTL_TX_REQUEST]) |->
                st_r.ctrl[i][CTL_BUS_ERROR +: 3] == 3'b000
        ) else $error("status flags kept on new request");

        abort_a: assert property (
            (wr_in && addr_in == ADR_PAIR_CTRL + 8'(i / 2) &&
             st_r.ctrl[i][CTL_TX_REQUEST] && !rtr_rx_in &&
             !(tx_ok_in && tx_valid_out) &&
             !wdata_in[(i % 2) * 8 + CTL_TX_REQUEST]) |=>
                tx_abort_out[i] && st_r.ctrl[i][CTL_ABORTED] &&
                !st_r.ctrl[i][CTL_TX_REQUEST] ##1 !tx_abort_out[i]
        ) else $error("abort not taken");

        rtr_reply_a: assert property (
            (rtr_rx_in && rtr_buf_in == 3'(i) &&
             st_r.ctrl[i][CTL_AUTO_REPLY]) |=> st_r.ctrl[i][CTL_TX_REQUEST]
        ) else $error("remote frame did not set request");

        prio_pick_a: assert property (
            (st_r.ctrl[i][CTL_TX_REQUEST] && st_r.ctrl[i][CTL_DIR_SELECT])
            |-> tx_valid_out &&
                (st_r.ctrl[tx_buf_out][1:0] > st_r.ctrl[i][1:0] ||
                 (st_r.ctrl[tx_buf_out][1:0] == st_r.ctrl[i][1:0] &&
                  tx_buf_out <= 3'(i)))
        ) else $error("wrong buffer offered");
    end

endmodule

//--- test/cbsc_bus_model.sv
// far-side transmit engine model that answers offered buffers
`timescale 1ns/100ps
module cbsc_bus_model (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // command from bench: result kind 1 ok, 2 lost, 3 error
    input  wire logic       go_in,
    input  wire logic [1:0] kind_in,
    input  wire logic [3:0] wait_in,
    // offered buffer
    input  wire logic       tx_valid_in,
    // results
    output logic            tx_ok_out,
    output logic            tx_lost_arb_out,
    output logic            tx_bus_err_out
);
    logic [1:0] kind_r;
    logic [3:0] cnt_r;
    logic       busy_r;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            kind_r          <= 2'h0;
            cnt_r           <= 4'h0;
            busy_r          <= 1'b0;
            tx_ok_out       <= 1'b0;
            tx_lost_arb_out <= 1'b0;
            tx_bus_err_out  <= 1'b0;
        end else begin
            tx_ok_out       <= 1'b0;
            tx_lost_arb_out <= 1'b0;
            tx_bus_err_out  <= 1'b0;
            if (go_in) begin
                busy_r <= 1'b1;
                cnt_r  <= wait_in;
                kind_r <= kind_in;
            end else if (busy_r && cnt_r != 4'h0) begin
                cnt_r <= cnt_r - 4'h1;
            end else if (busy_r && tx_valid_in) begin
                busy_r <= 1'b0;
                tx_ok_out       <= (kind_r == 2'h1);
                tx_lost_arb_out <= (kind_r == 2'h2);
                tx_bus_err_out  <= (kind_r == 2'h3);
            end
        end
    end
endmodule

//--- test/can_buffer_status_control_bench.sv
// self-checking bench for the can buffer status and control block
`timescale 1ns/100ps
module can_buffer_status_control_bench;
    import cbsc_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000, filt = 16'h0000, msg = 16'h0000;
    logic        wr = 1'b0, rd = 1'b0, rxw = 1'b0, srr = 1'b0, ide = 1'b0;
    logic [1:0]  msel = 2'h0, kind = 2'h0;
    logic [4:0]  rxb = 5'h00, hit = 5'h00;
    logic [10:0] sid = 11'h000;
    logic [11:0] eid = 12'h000;
    logic        rtr = 1'b0, go = 1'b0;
    logic [2:0]  rtrb = 3'h0, tx_buf;
    logic [3:0]  wt = 4'h0;
    logic [15:0] rdata;
    logic [7:0]  tx_abort;
    logic        match, tx_valid, ok, lost, err;
    int          failures = 0;
    int          checks = 0;

    always #10 clk_in = ~clk_in;

    cbsc_core u_dut (
        .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr),
        .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata),
        .filt_eid_in(filt), .msg_eid_in(msg), .mask_sel_in(msel),
        .ext_match_out(match), .rx_write_in(rxw), .rx_buf_in(rxb),
        .rx_sid_in(sid), .rx_srr_in(srr), .rx_ide_in(ide),
        .rx_eid_in(eid), .rx_filter_hit_in(hit), .rtr_rx_in(rtr),
        .rtr_buf_in(rtrb), .tx_ok_in(ok), .tx_lost_arb_in(lost),
        .tx_bus_err_in(err), .tx_valid_out(tx_valid),
        .tx_buf_out(tx_buf), .tx_abort_out(tx_abort)
    );

    cbsc_bus_model u_bus (
        .clk_in(clk_in), .rst_in(rst_in), .go_in(go), .kind_in(kind),
        .wait_in(wt), .tx_valid_in(tx_valid), .tx_ok_out(ok),
        .tx_lost_arb_out(lost), .tx_bus_err_out(err)
    );

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk_in);
        wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp,
                          input string name);
        @(posedge clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk_in);
        rd   <= 1'b0;
        #1 check(name, rdata, exp);
    endtask

    task automatic rx_store(input logic [4:0] b);
        @(posedge clk_in);
        rxw <= 1'b1;
        rxb <= b;
        @(posedge clk_in);
        rxw <= 1'b0;
    endtask

    task automatic tx_result(input logic [1:0] k, input logic [3:0] w);
        @(posedge clk_in);
        go   <= 1'b1;
        kind <= k;
        wt   <= w;
        @(posedge clk_in);
        go   <= 1'b0;
        repeat (20) @(posedge clk_in);
    endtask

    task automatic test_reset_values();
        for (int a = 4; a < 12; a++) begin
            rd_reg(8'(a), RST_WORD, "reset value");
        end
        rd_reg(8'h20, 16'h0000, "unmapped read");
        wr_reg(8'h20, 16'hFFFF);
        rd_reg(8'h20, 16'h0000, "unmapped write");
    endtask

    task automatic test_mask();
        for (int m = 0; m < 3; m++) begin
            wr_reg(8'(m), 16'h00FF << m);
            rd_reg(8'(m), 16'h00FF << m, "mask readback");
            @(posedge clk_in);
            msel <= 2'(m);
            // difference sits in bit 13, outside every mask used
            filt <= 16'h1000;
            msg  <= 16'h3000;
            @(posedge clk_in);
            #1 check("masked out bits", 16'(match), 16'h0001);
            @(posedge clk_in);
            msg <= 16'h3000 | (16'h0001 << m);
            @(posedge clk_in);
            #1 check("compared bit", 16'(match), 16'h0000);
        end
        @(posedge clk_in);
        msel <= 2'h3;
        msg  <= 16'h1000;
        @(posedge clk_in);
        #1 check("no mask", 16'(match), 16'h0000);
    endtask

    task automatic test_rx();
        sid <= 11'h5A3;
        srr <= 1'b1;
        ide <= 1'b0;
        eid <= 12'hABC;
        hit <= 5'h13;
        rx_store(5'd5);
        rx_store(5'd20);
        rd_reg(ADR_RX_FULL_FLAG_LO, 16'h0020, "full low");
        rd_reg(ADR_RX_FULL_FLAG_HI, 16'h0010, "full high");
        rd_reg(ADR_RX_OVERFLOW_FLAG_LO, 16'h0000, "no overflow");
        rx_store(5'd5);
        rd_reg(ADR_RX_OVERFLOW_FLAG_LO, 16'h0020, "overflow");
        rd_reg(8'h45, {3'b000, 11'h5A3, 2'b10}, "sid word");
        rd_reg(8'h65, {4'h0, 12'hABC}, "eid word");
        rd_reg(8'h85, {3'b000, 5'h13, 8'h00}, "hit code");
        wr_reg(8'h47, 16'hFFFF);
        rd_reg(8'h47, 16'h1FFF, "sid write");
        wr_reg(8'h67, 16'hFFFF);
        rd_reg(8'h67, 16'h0FFF, "eid write");
        wr_reg(8'h87, 16'hFFFF);
        rd_reg(8'h87, 16'h1F00, "hit write");
        wr_reg(ADR_RX_FULL_FLAG_LO, 16'hFFFF);
        rd_reg(ADR_RX_FULL_FLAG_LO, 16'h0020, "full kept");
        wr_reg(ADR_RX_FULL_FLAG_LO, 16'hFFDF);
        rd_reg(ADR_RX_FULL_FLAG_LO, 16'h0000, "full cleared");
        wr_reg(ADR_RX_OVERFLOW_FLAG_LO, 16'hFFFF);
        rd_reg(ADR_RX_OVERFLOW_FLAG_LO, 16'h0020, "overflow kept");
        wr_reg(ADR_RX_OVERFLOW_FLAG_LO, 16'h0000);
        rd_reg(ADR_RX_OVERFLOW_FLAG_LO, 16'h0000, "overflow cleared");
    endtask

    task automatic test_tx();
        wr_reg(8'h08, 16'h8988);
        wr_reg(8'h09, 16'h0089);
        @(posedge clk_in);
        #1 check("tx pending", 16'(tx_valid), 16'h0001);
        check("tie break", 16'(tx_buf), 16'h0001);
        tx_result(2'h1, 4'h0);
        rd_reg(8'h08, 16'h8188, "sent cleared");
        check("next offered", 16'(tx_buf), 16'h0002);
        tx_result(2'h2, 4'h5);
        rd_reg(8'h09, 16'h00A9, "lost arb");
        wr_reg(8'h09, 16'h0081);
        #1 check("abort pulse", 16'(tx_abort), 16'h0004);
        rd_reg(8'h09, 16'h00E1, "aborted");
        wr_reg(8'h09, 16'h0089);
        rd_reg(8'h09, 16'h0089, "flags cleared");
        tx_result(2'h3, 4'h2);
        rd_reg(8'h09, 16'h0099, "bus error");
        wr_reg(8'h09, 16'h0081);
        @(posedge clk_in);
        #1 check("low prio", 16'(tx_buf), 16'h0000);
        wr_reg(8'h08, 16'h0008);
        @(posedge clk_in);
        #1 check("rx buffer", 16'(tx_valid), 16'h0000);
        rd_reg(8'h08, 16'h0008, "direction rx");
    endtask

    task automatic test_remote(input logic [2:0] b, input logic [15:0] exp);
        @(posedge clk_in);
        rtr  <= 1'b1;
        rtrb <= b;
        @(posedge clk_in);
        rtr  <= 1'b0;
        rd_reg(8'h0A, exp, "remote reply");
    endtask

    initial begin
        repeat (8) @(posedge clk_in);
        rst_in <= 1'b0;
        test_reset_values();
        test_mask();
        test_rx();
        test_tx();
        wr_reg(8'h0A, 16'h8084);
        test_remote(3'h5, 16'h8084);
        test_remote(3'h4, 16'h808C);
        @(posedge clk_in);
        #1 check("reply offered", 16'(tx_buf), 16'h0004);
        check("reply valid", 16'(tx_valid), 16'h0001);
        report_and_stop();
    end

    // watchdog, tests need well under 1000 cycles
    initial begin
        #200000;
        failures++;
        report_and_stop();
    end
endmodule
